// *** verilog/tls_pkg.sv ***
`default_nettype none
package tls_pkg;
  // pointer offsets
  localparam logic [7:0] PTR_RESET      = 8'h00;
  localparam logic [7:0] PTR_STATUS     = 8'h02;
  localparam logic [7:0] RD_LOC_HI_HI   = 8'h05;
  localparam logic [7:0] RD_LOC_LO_HI   = 8'h06;
  localparam logic [7:0] RD_REM_HI_HI   = 8'h07;
  localparam logic [7:0] RD_REM_LO_HI   = 8'h08;
  localparam logic [7:0] WR_LOC_HI_HI   = 8'h0b;
  localparam logic [7:0] WR_LOC_LO_HI   = 8'h0c;
  localparam logic [7:0] WR_REM_HI_HI   = 8'h0d;
  localparam logic [7:0] WR_REM_LO_HI   = 8'h0e;
  localparam logic [7:0] PTR_REM_HI_LO  = 8'h13;
  localparam logic [7:0] PTR_REM_LO_LO  = 8'h14;
  localparam logic [7:0] PTR_LOC_HI_LO  = 8'h16;
  localparam logic [7:0] PTR_LOC_LO_LO  = 8'h17;
  localparam logic [7:0] PTR_REM_OT     = 8'h19;
  localparam logic [7:0] PTR_LOC_OT     = 8'h20;
  localparam logic [7:0] PTR_HYST       = 8'h21;
  // values after reset, then the low-byte write mask and the unmapped read value
  localparam logic [7:0] RST_HIGH_HI    = 8'h55;
  localparam logic [7:0] RST_LOW_HI     = 8'h00;
  localparam logic [7:0] RST_LIMIT_LO   = 8'h00;
  localparam logic [7:0] RST_LOC_OT     = 8'h55;
  localparam logic [7:0] RST_REM_OT     = 8'h55;
  localparam logic [7:0] RST_HYST       = 8'h0a;
  localparam logic [7:0] RST_STATUS     = 8'h00;
  localparam logic [7:0] LO_BYTE_MASK   = 8'hf0;
  localparam logic [7:0] UNMAPPED_READ  = 8'h00;
  // status bit positions
  localparam int BIT_BUSY   = 7;
  localparam int BIT_LUPPER = 6;
  localparam int BIT_LLOWER = 5;
  localparam int BIT_RUPPER = 4;
  localparam int BIT_RLOWER = 3;
  localparam int BIT_OPEN   = 2;
  localparam int BIT_ROT    = 1;
  localparam int BIT_LOT    = 0;

  typedef struct packed {
    logic       ptr_load;
    logic [7:0] ptr;
    logic       wr;
    logic [7:0] wr_data;
    logic       rd;
    logic       alert_resp;
  } tls_host_s;

  typedef struct packed {
    logic        busy;
    logic        done;
    logic        remote;
    logic        open;
    logic [11:0] result;
  } tls_conv_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } tls_rd_s;

  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] loc_hi_hi;
    logic [7:0] loc_hi_lo;
    logic [7:0] loc_lo_hi;
    logic [7:0] loc_lo_lo;
    logic [7:0] rem_hi_hi;
    logic [7:0] rem_hi_lo;
    logic [7:0] rem_lo_hi;
    logic [7:0] rem_lo_lo;
    logic [7:0] loc_ot;
    logic [7:0] rem_ot;
    logic [7:0] hyst;
    logic [7:0] status;
    logic [7:0] cond;
    logic       alert;
    logic       alert_n;
    logic       overtemp_n;
    tls_rd_s    rd;
  } tls_state_s;
endpackage
`default_nettype wire

// *** verilog/tls_temp_limit_status_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module tls_temp_limit_status_regs (
  input  wire logic              ref_clk_in,
  input  wire logic              nrst_in,
  input  wire tls_pkg::tls_host_s host_in,
  input  wire tls_pkg::tls_conv_s conv_in,
  input  wire logic              pin_function_select_in,
  output var  tls_pkg::tls_rd_s  rd_out,
  output logic                   alert_out_n,
  output logic                   overtemp_out_n,
  output logic [7:0]             monitor_flags_out
);
  import tls_pkg::*;

  tls_state_s s;
  tls_state_s next_s;

  // second byte of a two-byte transfer; used on both write and read paths
  function automatic logic [7:0] pair_ptr(input logic [7:0] p);
    unique case (p)
      WR_LOC_HI_HI, RD_LOC_HI_HI:
      begin
        pair_ptr = PTR_LOC_HI_LO;
      end
      WR_LOC_LO_HI, RD_LOC_LO_HI:
      begin
        pair_ptr = PTR_LOC_LO_LO;
      end
      WR_REM_HI_HI, RD_REM_HI_HI:
      begin
        pair_ptr = PTR_REM_HI_LO;
      end
      WR_REM_LO_HI, RD_REM_LO_HI:
      begin
        pair_ptr = PTR_REM_LO_LO;
      end
      default:
      begin
        pair_ptr = p;
      end
    endcase
  endfunction

  // true when the result has fallen hysteresis below the limit
  function automatic logic below_hyst(input logic [11:0] res,
                                      input logic [11:0] lim,
                                      input logic [7:0]  hy);
    below_hyst = ({1'b0, res} + {1'b0, hy, 4'h0}) < {1'b0, lim};
  endfunction

  function automatic logic [7:0] read_mux(input tls_state_s st);
    unique case (st.ptr)
      PTR_STATUS:
      begin
        read_mux = st.status;
      end
      RD_LOC_HI_HI:
      begin
        read_mux = st.loc_hi_hi;
      end
      PTR_LOC_HI_LO:
      begin
        read_mux = st.loc_hi_lo;
      end
      RD_LOC_LO_HI:
      begin
        read_mux = st.loc_lo_hi;
      end
      PTR_LOC_LO_LO:
      begin
        read_mux = st.loc_lo_lo;
      end
      RD_REM_HI_HI:
      begin
        read_mux = st.rem_hi_hi;
      end
      PTR_REM_HI_LO:
      begin
        read_mux = st.rem_hi_lo;
      end
      RD_REM_LO_HI:
      begin
        read_mux = st.rem_lo_hi;
      end
      PTR_REM_LO_LO:
      begin
        read_mux = st.rem_lo_lo;
      end
      PTR_LOC_OT:
      begin
        read_mux = st.loc_ot;
      end
      PTR_REM_OT:
      begin
        read_mux = st.rem_ot;
      end
      PTR_HYST:
      begin
        read_mux = st.hyst;
      end
      default:
      begin
        read_mux = UNMAPPED_READ;
      end
    endcase
  endfunction

  logic [11:0] ch_hi [2];
  logic [11:0] ch_lo [2];
  logic [11:0] ch_ot [2];
  logic [1:0]  hi_over;
  logic [1:0]  hi_clear;
  logic [1:0]  lo_under;
  logic [1:0]  ot_over;
  logic [1:0]  ot_clear;
  logic [7:0]  latch_mask;
  logic [7:0]  set_v;
  logic [7:0]  clr_v;
  logic        st_read;

  // index 0 is the local channel, 1 the remote one
  assign ch_hi[0] = {s.loc_hi_hi, s.loc_hi_lo[7:4]};
  assign ch_hi[1] = {s.rem_hi_hi, s.rem_hi_lo[7:4]};
  assign ch_lo[0] = {s.loc_lo_hi, s.loc_lo_lo[7:4]};
  assign ch_lo[1] = {s.rem_lo_hi, s.rem_lo_lo[7:4]};
  assign ch_ot[0] = {s.loc_ot, 4'h0};
  assign ch_ot[1] = {s.rem_ot, 4'h0};

  // both channels share one comparator shape; only the limits differ
  for (genvar g = 0; g < 2; g++)
  begin : gen_chan
    assign hi_over[g]  = conv_in.result > ch_hi[g];
    assign hi_clear[g] = below_hyst(conv_in.result, ch_hi[g], s.hyst);
    assign lo_under[g] = conv_in.result < ch_lo[g];
    assign ot_over[g]  = conv_in.result > ch_ot[g];
    assign ot_clear[g] = below_hyst(conv_in.result, ch_ot[g], s.hyst);
  end

  always_comb
  begin
    next_s     = s;
    set_v      = 8'h00;
    clr_v      = 8'h00;
    latch_mask = 8'h00;
    next_s.rd.valid = 1'b0;
    // a read that loses to a write or pointer load must not clear flags
    st_read    = host_in.rd && !host_in.ptr_load && !host_in.wr && (s.ptr == PTR_STATUS);

    next_s.status[BIT_BUSY] = conv_in.busy;

    if (conv_in.done)
    begin
      if (conv_in.remote)
      begin
        next_s.cond[BIT_RUPPER] = hi_over[1];
        next_s.cond[BIT_RLOWER] = lo_under[1];
        next_s.cond[BIT_OPEN]   = conv_in.open;
        if (ot_over[1])
        begin
          next_s.status[BIT_ROT] = 1'b1;
        end
        else if (ot_clear[1])
        begin
          next_s.status[BIT_ROT] = 1'b0;
        end
        if (pin_function_select_in)
        begin
          if (hi_over[1])
          begin
            next_s.status[BIT_RUPPER] = 1'b1;
          end
          else if (hi_clear[1])
          begin
            next_s.status[BIT_RUPPER] = 1'b0;
          end
        end
      end
      else
      begin
        next_s.cond[BIT_LUPPER] = hi_over[0];
        next_s.cond[BIT_LLOWER] = lo_under[0];
        if (ot_over[0])
        begin
          next_s.status[BIT_LOT] = 1'b1;
        end
        else if (ot_clear[0])
        begin
          next_s.status[BIT_LOT] = 1'b0;
        end
        if (pin_function_select_in)
        begin
          if (hi_over[0])
          begin
            next_s.status[BIT_LUPPER] = 1'b1;
          end
          else if (hi_clear[0])
          begin
            next_s.status[BIT_LUPPER] = 1'b0;
          end
        end
      end
    end

    latch_mask[BIT_LLOWER] = 1'b1;
    latch_mask[BIT_RLOWER] = 1'b1;
    latch_mask[BIT_OPEN]   = 1'b1;
    latch_mask[BIT_LUPPER] = !pin_function_select_in;
    latch_mask[BIT_RUPPER] = !pin_function_select_in;

    // cond already holds this conversion's verdict for the finished channel
    set_v = conv_in.done ? (next_s.cond & latch_mask) : 8'h00;
    clr_v = st_read ? (latch_mask & ~next_s.cond) : 8'h00;
    // live bits untouched
    // a set in the clearing cycle wins, so no event is lost
    next_s.status = (next_s.status & ~(latch_mask & clr_v)) | set_v;

    if (!pin_function_select_in && |(set_v & ~s.status))
      next_s.alert = 1'b1;
    else if (host_in.alert_resp)
      next_s.alert = 1'b0;

    if (pin_function_select_in)
      next_s.alert_n = !(next_s.status[BIT_LUPPER] || next_s.status[BIT_RUPPER]);
    else
      next_s.alert_n = !next_s.alert;
    next_s.overtemp_n = !(next_s.status[BIT_LOT] || next_s.status[BIT_ROT]);

    if (host_in.ptr_load)
      next_s.ptr = host_in.ptr;
    else if (host_in.wr)
    begin
      next_s.ptr = pair_ptr(s.ptr);
      unique case (s.ptr)
        WR_LOC_HI_HI:
        begin
          next_s.loc_hi_hi = host_in.wr_data;
        end
        PTR_LOC_HI_LO:
        begin
          next_s.loc_hi_lo = host_in.wr_data & LO_BYTE_MASK;
        end
        WR_LOC_LO_HI:
        begin
          next_s.loc_lo_hi = host_in.wr_data;
        end
        PTR_LOC_LO_LO:
        begin
          next_s.loc_lo_lo = host_in.wr_data & LO_BYTE_MASK;
        end
        WR_REM_HI_HI:
        begin
          next_s.rem_hi_hi = host_in.wr_data;
        end
        PTR_REM_HI_LO:
        begin
          next_s.rem_hi_lo = host_in.wr_data & LO_BYTE_MASK;
        end
        WR_REM_LO_HI:
        begin
          next_s.rem_lo_hi = host_in.wr_data;
        end
        PTR_REM_LO_LO:
        begin
          next_s.rem_lo_lo = host_in.wr_data & LO_BYTE_MASK;
        end
        PTR_LOC_OT:
        begin
          next_s.loc_ot = host_in.wr_data;
        end
        PTR_REM_OT:
        begin
          next_s.rem_ot = host_in.wr_data;
        end
        PTR_HYST:
        begin
          next_s.hyst = host_in.wr_data;
        end
        default:
        begin
          next_s.hyst = s.hyst;
        end
      endcase
    end
    else if (host_in.rd)
    begin
      // status shows pre-clear value, so a read never hides a flag
      next_s.rd.data  = read_mux(s);
      next_s.rd.valid = 1'b1;
      next_s.ptr      = pair_ptr(s.ptr);
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      s.ptr        <= PTR_RESET;
      s.loc_hi_hi  <= RST_HIGH_HI;
      s.rem_hi_hi  <= RST_HIGH_HI;
      s.loc_lo_hi  <= RST_LOW_HI;
      s.rem_lo_hi  <= RST_LOW_HI;
      s.loc_hi_lo  <= RST_LIMIT_LO;
      s.loc_lo_lo  <= RST_LIMIT_LO;
      s.rem_hi_lo  <= RST_LIMIT_LO;
      s.rem_lo_lo  <= RST_LIMIT_LO;
      s.loc_ot     <= RST_LOC_OT;
      s.rem_ot     <= RST_REM_OT;
      s.hyst       <= RST_HYST;
      s.status     <= RST_STATUS;
      s.cond       <= RST_STATUS;
      s.alert      <= 1'b0;
      s.alert_n    <= 1'b1;
      s.overtemp_n <= 1'b1;
      s.rd         <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign rd_out            = s.rd;
  assign alert_out_n       = s.alert_n;
  assign overtemp_out_n    = s.overtemp_n;
  assign monitor_flags_out = s.status;
endmodule
`default_nettype wire

// *** test/tls_limit_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module tls_limit_asserts (
  input wire logic               ref_clk_in,
  input wire logic               nrst_in,
  input wire tls_pkg::tls_host_s host_in,
  input wire tls_pkg::tls_conv_s conv_in,
  input wire logic               pin_function_select_in,
  input wire tls_pkg::tls_rd_s   rd_out,
  input wire logic               alert_out_n,
  input wire logic               overtemp_out_n,
  input wire logic [7:0]         monitor_flags_out
);
  import tls_pkg::*;
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (!nrst_in);
  sequence s_rd_req;
    host_in.rd && !host_in.ptr_load && !host_in.wr;
  endsequence
  rd_answer_a:
    assert property (s_rd_req |=> rd_out.valid) else $error("read unanswered");
  busy_flag_a:
    assert property (conv_in.busy |=> monitor_flags_out[BIT_BUSY]) else $error("busy low");
  overtemp_pin_a:
    assert property (overtemp_out_n == !(monitor_flags_out[BIT_ROT] || monitor_flags_out[BIT_LOT]))
      else $error("overtemp pin");
  second_pin_a:
    assert property ($past(pin_function_select_in) |->
      alert_out_n == !(monitor_flags_out[BIT_LUPPER] || monitor_flags_out[BIT_RUPPER]))
      else $error("second pin");
  // mode switches excluded, though flags change only on a done or a status read
  flags_still_a:
    assert property (!conv_in.done && !host_in.rd && $stable(pin_function_select_in) |=>
      $stable(monitor_flags_out[6:0])) else $error("flags moved");
  lower_latch_a:
    assert property (monitor_flags_out[BIT_LLOWER] && !host_in.rd |=>
      monitor_flags_out[BIT_LLOWER]) else $error("lower flag dropped");
  alert_hold_a:
    assert property (!pin_function_select_in && !$past(pin_function_select_in) && !alert_out_n
      && !host_in.alert_resp |=> !alert_out_n) else $error("alert released");
  alert_rise_a:
    assert property (!$past(pin_function_select_in) &&
      |(monitor_flags_out[6:2] & ~$past(monitor_flags_out[6:2])) |-> !alert_out_n)
      else $error("alert not raised");
endmodule
bind tls_temp_limit_status_regs tls_limit_asserts chk_u (.ref_clk_in(ref_clk_in),
  .nrst_in(nrst_in), .host_in(host_in), .conv_in(conv_in),
  .pin_function_select_in(pin_function_select_in), .rd_out(rd_out),
  .alert_out_n(alert_out_n), .overtemp_out_n(overtemp_out_n),
  .monitor_flags_out(monitor_flags_out));
`default_nettype wire

// *** test/tls_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module tls_host_model (
  input  wire logic               ref_clk_in,
  input  wire tls_pkg::tls_rd_s   rd_in,
  output var  tls_pkg::tls_host_s host_out
);
  import tls_pkg::*;
  initial host_out = '0;
  task automatic op(input logic [3:0] k, input logic [7:0] p, input logic [7:0] d,
                    output logic [8:0] q);
    @(posedge ref_clk_in);
    host_out <= {k[3], p, k[2], d, k[1], k[0]};
    @(posedge ref_clk_in);
    // released lines show the inverse so a stale value never passes
    host_out <= {1'b0, ~p, 1'b0, ~d, 2'b00};
    #1;
    q = {rd_in.valid, rd_in.data};
  endtask
endmodule
`default_nettype wire

// *** test/tls_temp_limit_status_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tls_temp_limit_status_regs_tb;
  import tls_pkg::*;
  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic        mode  = 1'b0;
  tls_conv_s   conv  = '0;
  tls_host_s   host;
  tls_rd_s     rd;
  logic        al_n;
  logic        ot_n;
  logic [7:0]  fl;
  logic [8:0]  q;
  int          fail_count  = 0;
  int          comparisons = 0;
  logic [15:0] rst_t [12] = '{16'h0555, 16'h0600, 16'h0755, 16'h0800, 16'h1300, 16'h1400,
    16'h1600, 16'h1955, 16'h2055, 16'h210a, 16'h0200, 16'h3000};
  logic [31:0] lim_t [4]  = '{32'h0b05608c, 32'h0c061000, 32'h0d074000, 32'h0e080500};
  always #5 clk = ~clk;
  tls_host_model host_u (.ref_clk_in(clk), .rd_in(rd), .host_out(host));
  tls_temp_limit_status_regs dut_u (.ref_clk_in(clk), .nrst_in(rst_n), .host_in(host),
    .conv_in(conv), .pin_function_select_in(mode), .rd_out(rd), .alert_out_n(al_n),
    .overtemp_out_n(ot_n), .monitor_flags_out(fl));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd_now(input logic [7:0] e);
    host_u.op(4'b0010, 8'h00, 8'h00, q);
    chk("read", q[7:0], e);
    chk("valid", {7'h0, q[8]}, 8'h01);
  endtask
  task automatic rd_reg(input logic [7:0] p, input logic [7:0] e);
    host_u.op(4'b1000, p, 8'h00, q);
    rd_now(e);
  endtask
  task automatic wr_reg(input logic [7:0] p, input logic [7:0] d);
    host_u.op(4'b1000, p, 8'h00, q);
    host_u.op(4'b0100, 8'h00, d, q);
  endtask
  // pins vector is {alert, overtemp}, both active low
  task automatic cv(input logic r, input logic o, input logic [11:0] t, input logic [7:0] e,
                    input logic [7:0] pins);
    @(posedge clk);
    conv <= '{1'b1, 1'b0, r, o, t};
    @(posedge clk);
    conv <= '{1'b0, 1'b1, r, o, t};
    #1;
    chk("busy", {7'h0, fl[7]}, 8'h01);
    @(posedge clk);
    conv <= '0;
    #1;
    chk("flags", fl, e);
    chk("pins", {6'h0, al_n, ot_n}, pins);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rst_t[i]) rd_reg(rst_t[i][15:8], rst_t[i][7:0]);
    $display("reset values done");
    foreach (lim_t[i])
    begin
      wr_reg(lim_t[i][31:24], lim_t[i][15:8]);
      host_u.op(4'b0100, 8'h00, lim_t[i][7:0], q);
      rd_reg(lim_t[i][23:16], lim_t[i][15:8]);
      rd_now(lim_t[i][7:0] & 8'hf0);
    end
    rd_reg(8'h16, 8'h80);
    wr_reg(8'h02, 8'hff);
    rd_reg(8'h02, 8'h00);
    wr_reg(8'h20, 8'h70);
    wr_reg(8'h19, 8'h50);
    rd_reg(8'h20, 8'h70);
    rd_reg(8'h19, 8'h50);
    $display("limit access done");
    cv(1'b0, 1'b0, 12'h709, 8'h41, 8'h00);
    rd_reg(8'h02, 8'h41);
    cv(1'b0, 1'b0, 12'h200, 8'h40, 8'h01);
    rd_reg(8'h02, 8'h40);
    chk("flags", fl, 8'h00);
    chk("alert", {7'h0, al_n}, 8'h00);
    host_u.op(4'b0001, 8'h00, 8'h00, q);
    chk("alert", {7'h0, al_n}, 8'h01);
    cv(1'b1, 1'b1, 12'h010, 8'h0c, 8'h01);
    cv(1'b1, 1'b0, 12'h200, 8'h0c, 8'h01);
    rd_reg(8'h02, 8'h0c);
    chk("flags", fl, 8'h00);
    host_u.op(4'b0001, 8'h00, 8'h00, q);
    $display("alert mode done");
    @(posedge clk);
    mode <= 1'b1;
    cv(1'b1, 1'b0, 12'h450, 8'h10, 8'h01);
    rd_reg(8'h02, 8'h10);
    chk("flags", fl, 8'h10);
    cv(1'b1, 1'b0, 12'h300, 8'h00, 8'h03);
    $display("comparator mode done");
    end_of_test();
  end
  initial
  begin
    #100000;
    fail_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
